// File: design/rbs_cmd_if.sv
// Purpose: command carrier between register file and pin sequencer
// Assumes: single clock
// Notes:   go is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/1ps
interface rbs_cmd_if;
  logic              go;     // start one access
  logic              write;  // 1 write, 0 read
  rbs_pkg::rbs_addr_t addr;  // byte address
  rbs_pkg::rbs_byte_t wdata; // write byte
  rbs_pkg::rbs_byte_t rdata; // captured read byte
  logic              done;   // access finished
  logic              busy;   // sequencer active
  modport master (output go, write, addr, wdata, input rdata, done, busy);
  modport slave  (input go, write, addr, wdata, output rdata, done, busy);
endinterface : rbs_cmd_if

// File: design/rbs_host_top.sv
// Purpose: apb-controlled host for a battery-backed clock memory
// Assumes: 25 MHz clock_i, device pins asynchronous
// Notes:   one byte access per command
// Summary of operation
// R1: clock bytes sit at top eight addresses
// R2: time fields are bcd, 24-hour
// R3: device calendar handles month lengths, leaps
// R4: lowest clock byte is control byte
// R5: clock bytes refreshed each second by device
// R6: clock bytes use ordinary access protocol
// R7: low supply blocks writes, releases data
// R8: chip on, store high means read
// R9: fifteen address bits pick one byte
// R10: device drives data only on read enable
// R11: data undefined until access completes
// R12: chip on and store low means write
// R13: write starts at later falling strobe
// R14: write ends at earlier rising strobe
// R15: host holds address through whole write
// R16: host keeps strobes high for recovery
// R17: host sets data before, holds after edge
// R18: host keeps output drive high writing
// R19: falling store releases device data drive
// R20: simultaneous falls never drive data
// R21: halt copy flag freezes clock bytes
// R22: set time flag loads counters on clear
// R23: seconds top bit stops oscillator
// R24: clock bytes refresh together, never mixed
`timescale 1ns/1ps
`include "rbs_params.svh"
module rbs_host_top (
  input  wire logic        clock_i,          // 25 MHz clock
  input  wire logic        srst_i,           // sync reset, high
  input  wire logic        ce_i,             // clock enable
  input  wire logic        psel_i,           // apb select
  input  wire logic        penable_i,        // apb enable
  input  wire logic        pwrite_i,         // apb direction
  input  wire logic [11:0] paddr_i,          // apb address
  input  wire logic [31:0] pwdata_i,         // apb write data
  output logic      [31:0] prdata_o,         // apb read data
  output logic             pready_o,         // apb ready
  output logic             pslverr_o,        // apb error
  output logic      [14:0] addr_lines_o,     // device address
  output logic             chip_on_n_o,      // device chip select
  output logic             output_drive_n_o, // device output enable
  output logic             store_strobe_n_o, // device write strobe
  input  wire logic [7:0]  data_lines_i,     // data pins in
  output logic      [7:0]  data_lines_o,     // data pins out
  output logic             data_lines_oe_o   // data pins driven
);
  rbs_cmd_if cmd ();
  logic [7:0]  sync1_q, sync2_q;
  logic [14:0] addr_q, addr_d;
  logic [7:0]  wdata_q, wdata_d;
  logic        wr_q, wr_d, go_q, go_d, done_q, done_d;
  logic [31:0] prdata_d;
  logic        pready_d, pslverr_d;

  function automatic logic is_clock_byte(input logic [14:0] a);
    is_clock_byte = (a >= `RBS_CLK_FIRST) && (a <= `RBS_CLK_LAST);
  endfunction : is_clock_byte

  assign cmd.go    = go_q;
  assign cmd.write = wr_q;
  assign cmd.addr  = addr_q;
  assign cmd.wdata = wdata_q;

  // two-stage synchroniser on data pins
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else if (ce_i) begin
      sync1_q <= data_lines_i;
      sync2_q <= sync1_q;
    end
  end

  rbs_pin_seq u_seq (
    .clock_i     (clock_i),
    .srst_i      (srst_i),
    .ce_i        (ce_i),
    .data_sync_i (sync2_q),
    .addr_q      (addr_lines_o),
    .chip_on_n_q (chip_on_n_o),
    .out_drv_n_q (output_drive_n_o),
    .store_n_q   (store_strobe_n_o),
    .dout_q      (data_lines_o),
    .doe_q       (data_lines_oe_o),
    .cmd         (cmd)
  );

  // apb register file, zero wait states
  always_comb begin
    addr_d = addr_q; wdata_d = wdata_q; wr_d = wr_q; go_d = 1'b0;
    done_d = done_q | cmd.done;              // sticky done, set wins
    prdata_d = 32'h0000_0000; pready_d = 1'b0; pslverr_d = 1'b0;
    if (psel_i && !penable_i) begin
      pready_d = 1'b1;
      case (paddr_i)
        `RBS_OFS_CTRL: begin
          if (pwrite_i && pwdata_i[`RBS_CTRL_GO_BIT] && !cmd.busy && !go_q) begin
            go_d   = 1'b1;
            wr_d   = pwdata_i[`RBS_CTRL_WR_BIT];
            done_d = cmd.done;               // clear by new go, set still wins
          end
          prdata_d = {30'h0000_0000, wr_q, 1'b0};
        end
        `RBS_OFS_ADDR: begin
          if (pwrite_i) addr_d = pwdata_i[14:0];
          prdata_d = {17'h0_0000, addr_q};
        end
        `RBS_OFS_WDATA: begin
          if (pwrite_i) wdata_d = pwdata_i[7:0];
          prdata_d = {24'h00_0000, wdata_q};
        end
        `RBS_OFS_RDATA:  prdata_d = {24'h00_0000, cmd.rdata};
        `RBS_OFS_STATUS: prdata_d = {29'h0000_0000, is_clock_byte(addr_q),
                                     done_q, cmd.busy | go_q};
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  // register file state
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      addr_q <= 15'h0000; wdata_q <= 8'h00; wr_q <= 1'b0; go_q <= 1'b0;
      done_q <= 1'b0; prdata_o <= 32'h0000_0000; pready_o <= 1'b0; pslverr_o <= 1'b0;
    end else if (ce_i) begin
      addr_q <= addr_d; wdata_q <= wdata_d; wr_q <= wr_d; go_q <= go_d;
      done_q <= done_d; prdata_o <= prdata_d; pready_o <= pready_d;
      pslverr_o <= pslverr_d;
    end
  end
endmodule : rbs_host_top

// File: design/rbs_params.svh
// Purpose: constants for the battery-backed clock memory host controller
// Assumes: 25 MHz clock_i, 40 ns period
// Notes:   offsets are byte addresses on the apb side
`ifndef RBS_PARAMS_SVH
`define RBS_PARAMS_SVH
// apb register offsets
`define RBS_OFS_CTRL        12'h000
`define RBS_OFS_ADDR        12'h004
`define RBS_OFS_WDATA       12'h008
`define RBS_OFS_RDATA       12'h00c
`define RBS_OFS_STATUS      12'h010
// device memory map
`define RBS_CLK_FIRST       15'h7ff8
`define RBS_CLK_LAST        15'h7fff
`define RBS_CLOCK_CTRL      15'h7ff8
`define RBS_SECONDS         15'h7ff9
// control byte and seconds byte fields
`define RBS_SET_TIME_BIT    7
`define RBS_HALT_COPY_BIT   6
`define RBS_OSC_HALT_BIT    7
// ctrl register fields
`define RBS_CTRL_GO_BIT     0
`define RBS_CTRL_WR_BIT     1
// pin timing in ns
`define RBS_T_ACCESS_NS     70
`define RBS_T_WPULSE_NS     55
`define RBS_T_DSETUP_NS     30
`define RBS_T_RECOVER_NS    70
`define RBS_CLK_NS          40
// cycles, least times rounded up
`define RBS_CYC(ns)         (((ns) + `RBS_CLK_NS - 1) / `RBS_CLK_NS)
`define RBS_ACCESS_CYC      `RBS_CYC(`RBS_T_ACCESS_NS)
`define RBS_WPULSE_CYC      `RBS_CYC(`RBS_T_WPULSE_NS)
`define RBS_RECOVER_CYC     `RBS_CYC(`RBS_T_RECOVER_NS)
`endif

// File: design/rbs_pin_seq.sv
// Purpose: drives the asynchronous byte-wide memory pins for one access
// Assumes: data input already synchronised by the caller
// Notes:   all pin outputs come from flip-flops
`timescale 1ns/1ps
`include "rbs_params.svh"
module rbs_pin_seq (
  input  wire logic         clock_i,     // system clock
  input  wire logic         srst_i,      // sync reset
  input  wire logic         ce_i,        // clock enable
  input  wire logic [7:0]   data_sync_i, // synchronised data_lines
  output logic [14:0]       addr_q,      // addr_lines
  output logic              chip_on_n_q, // chip select
  output logic              out_drv_n_q, // output enable
  output logic              store_n_q,   // write strobe
  output logic [7:0]        dout_q,      // data_lines out
  output logic              doe_q,       // data_lines enable
  rbs_cmd_if.slave          cmd          // command side
);
  rbs_pkg::rbs_state_t st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [14:0] addr_d;
  logic        ce_n_d, oe_n_d, we_n_d, doe_d, wr_q, wr_d, done_q, done_d;
  logic [7:0]  dout_d, rd_q, rd_d;

  assign cmd.rdata = rd_q;
  assign cmd.done  = done_q;
  assign cmd.busy  = (st_q != rbs_pkg::RBS_IDLE);

  // next-state logic of the pin sequence
  always_comb begin
    st_d = st_q; cnt_d = cnt_q; addr_d = addr_q; ce_n_d = chip_on_n_q;
    oe_n_d = out_drv_n_q; we_n_d = store_n_q; dout_d = dout_q; doe_d = doe_q;
    wr_d = wr_q; rd_d = rd_q; done_d = 1'b0;
    case (st_q)
      rbs_pkg::RBS_IDLE: begin
        if (cmd.go) begin
          addr_d = cmd.addr;                 // address set before any strobe [R9] [R15]
          wr_d   = cmd.write;
          dout_d = cmd.wdata;
          st_d   = rbs_pkg::RBS_SETUP;
        end
      end
      rbs_pkg::RBS_SETUP: begin
        ce_n_d = 1'b0;                       // same protocol for clock bytes [R1] [R6]
        if (wr_q) begin
          we_n_d = 1'b0;                     // write starts at later fall [R12] [R13]
          oe_n_d = 1'b1;                     // no contention on write [R18] [R20]
          doe_d  = 1'b1;                     // data ahead of rising edge [R17]
          cnt_d  = 4'(`RBS_WPULSE_CYC);
        end else begin
          we_n_d = 1'b1;                     // read selected [R8]
          oe_n_d = 1'b0;                     // device drives only now [R10]
          doe_d  = 1'b0;
          cnt_d  = 4'(`RBS_ACCESS_CYC + 2);  // access plus pin sync [R11]
        end
        st_d = rbs_pkg::RBS_STROBE;
      end
      rbs_pkg::RBS_STROBE: begin
        if (cnt_q > 4'd1) begin
          cnt_d = cnt_q - 4'd1;
        end else begin
          st_d = rbs_pkg::RBS_SAMPLE;
        end
      end
      rbs_pkg::RBS_SAMPLE: begin
        if (!wr_q) begin
          rd_d = data_sync_i;                // read after access settles [R11]
        end
        ce_n_d = 1'b1;                       // write ends at earliest rise [R14]
        we_n_d = 1'b1;
        oe_n_d = 1'b1;
        cnt_d  = 4'(`RBS_RECOVER_CYC);
        st_d   = rbs_pkg::RBS_RECOVER;
      end
      rbs_pkg::RBS_RECOVER: begin
        doe_d = 1'b0;                        // data held past edge [R17]
        if (cnt_q > 4'd1) begin
          cnt_d = cnt_q - 4'd1;              // strobes high recovery [R16]
        end else begin
          done_d = 1'b1;
          st_d   = rbs_pkg::RBS_IDLE;        // address kept until after edge [R15]
        end
      end
      default: st_d = rbs_pkg::RBS_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st_q <= rbs_pkg::RBS_IDLE; cnt_q <= 4'h0; addr_q <= 15'h0000;
      chip_on_n_q <= 1'b1; out_drv_n_q <= 1'b1; store_n_q <= 1'b1;
      dout_q <= 8'h00; doe_q <= 1'b0; wr_q <= 1'b0; rd_q <= 8'h00; done_q <= 1'b0;
    end else if (ce_i) begin
      st_q <= st_d; cnt_q <= cnt_d; addr_q <= addr_d;
      chip_on_n_q <= ce_n_d; out_drv_n_q <= oe_n_d; store_n_q <= we_n_d;
      dout_q <= dout_d; doe_q <= doe_d; wr_q <= wr_d; rd_q <= rd_d; done_q <= done_d;
    end
  end
endmodule : rbs_pin_seq

// File: design/rbs_pkg.sv
// Purpose: types for the battery-backed clock memory host controller
// Assumes: nothing
// Notes:   constants live in rbs_params.svh
package rbs_pkg;
  typedef enum logic [2:0] {
    RBS_IDLE,
    RBS_SETUP,
    RBS_STROBE,
    RBS_SAMPLE,
    RBS_RECOVER
  } rbs_state_t;
  typedef logic [14:0] rbs_addr_t;
  typedef logic [7:0]  rbs_byte_t;
endpackage : rbs_pkg

// File: testbench/rbs_host_asserts.sv
// Purpose: pin sequence checks for the clock memory host
// Assumes: sees only the ports of rbs_host_top
// Notes:   bound at the foot of this file
`timescale 1ns/1ps
module rbs_host_asserts (
  input wire logic        clock_i,          // system clock
  input wire logic        srst_i,           // sync reset
  input wire logic [14:0] addr_lines_o,     // device address
  input wire logic        chip_on_n_o,      // chip select
  input wire logic        output_drive_n_o, // output enable
  input wire logic        store_strobe_n_o, // write strobe
  input wire logic [7:0]  data_lines_o,     // write byte
  input wire logic        data_lines_oe_o   // data driven
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // bus contention and mode selection
  AST_OE_WRITE: assert property (data_lines_oe_o |-> output_drive_n_o)
    else $error("host drives data with output enable low");
  AST_RD_NO_STORE: assert property (!output_drive_n_o |-> store_strobe_n_o)
    else $error("read enable with write strobe low");
  AST_WR_SEL: assert property (!store_strobe_n_o |-> !chip_on_n_o)
    else $error("write strobe without chip select");
  AST_ADDR_HOLD: assert property (!chip_on_n_o |-> $stable(addr_lines_o))
    else $error("address moved during access");
  // pulse widths and recovery, 55 ns and 70 ns at 40 ns
  AST_WPULSE: assert property ($fell(store_strobe_n_o) |-> !store_strobe_n_o [*2])
    else $error("write pulse too short");
  AST_RECOVER: assert property ($rose(chip_on_n_o) |-> chip_on_n_o [*2])
    else $error("chip select recovery too short");
  // data setup before and hold at the ending edge
  AST_DSETUP: assert property ($rose(store_strobe_n_o) |->
    $past(data_lines_oe_o) && data_lines_oe_o && $stable(data_lines_o))
    else $error("write data not held across strobe rise");
  AST_OE_RELEASE: assert property ($fell(data_lines_oe_o) |-> chip_on_n_o && store_strobe_n_o)
    else $error("data released before write ended");
  // main scenarios
  cover property ($fell(store_strobe_n_o));
  cover property ($fell(output_drive_n_o));
  cover property ($rose(chip_on_n_o) && store_strobe_n_o);
endmodule : rbs_host_asserts

bind rbs_host_top rbs_host_asserts chk_u (.clock_i, .srst_i, .addr_lines_o, .chip_on_n_o,
  .output_drive_n_o, .store_strobe_n_o, .data_lines_o, .data_lines_oe_o);

// File: testbench/rbs_mem_model.sv
// Purpose: behavioural battery-backed clock memory on the far side
// Assumes: strobes are levels, the device has no clock
// Notes:   released lines show the inverse of the last byte
`timescale 1ns/1ps
module rbs_mem_model (
  input  wire logic [14:0] addr_i,    // address lines
  input  wire logic        chip_n_i,  // chip select
  input  wire logic        out_n_i,   // output enable
  input  wire logic        store_n_i, // write strobe
  input  wire logic [7:0]  host_d_i,  // host data
  input  wire logic        host_oe_i, // host drives data
  output logic      [7:0]  dq_o       // resolved data lines
);
  rbs_pkg::rbs_byte_t mem [0:32767]; // flat array, clock bytes at top
  // clock bytes are plain storage; no refresh runs here
  // counters, halt, set and stop flags are left to the real part
  logic [7:0]         last_q = 8'h00;
  logic               supply_ok = 1'b1; // supply monitor, held good here
  logic               wr;
  logic               rd;
  // mode decode from strobe levels
  assign wr = supply_ok && !chip_n_i && !store_n_i;
  assign rd = supply_ok && !chip_n_i && !out_n_i && store_n_i;
  // commit at the earlier rising strobe
  always @(negedge wr) if (host_oe_i === 1'b1) mem[addr_i] = host_d_i;
  // wire level from both drivers, inverted when released
  always_comb dq_o = rd ? mem[addr_i] : (host_oe_i ? host_d_i : ~last_q);
  always @(dq_o) if (rd || host_oe_i) last_q <= dq_o;
endmodule : rbs_mem_model

// File: testbench/rtc_backed_sram_port_tb_top.sv
// Purpose: self-checking bench for the clock memory host
// Assumes: zero-wait apb slave, one byte per command
// Notes:   memory model stands on the pins
`timescale 1ns/1ps
`include "rbs_params.svh"
module rtc_backed_sram_port_tb_top;
  logic        clock_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o, rd, st;
  logic        pready_o, pslverr_o, er, chip_on_n_o, output_drive_n_o, store_strobe_n_o;
  logic        data_lines_oe_o;
  logic [14:0] addr_lines_o;
  logic [7:0]  data_lines_i, data_lines_o;
  int          n_mismatch = 0;
  int          comparisons = 0;
  // 25 MHz clock
  always #20 clock_i = ~clock_i;
  rbs_host_top dut_u (.clock_i, .srst_i, .ce_i(1'b1), .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .addr_lines_o, .chip_on_n_o, .output_drive_n_o,
    .store_strobe_n_o, .data_lines_i, .data_lines_o, .data_lines_oe_o);
  rbs_mem_model mem_u (.addr_i(addr_lines_o), .chip_n_i(chip_on_n_o), .out_n_i(output_drive_n_o),
    .store_n_i(store_strobe_n_o), .host_d_i(data_lines_o), .host_oe_i(data_lines_oe_o),
    .dq_o(data_lines_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  // one apb transfer, held until pready
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    {psel_i, penable_i, paddr_i, pwrite_i, pwdata_i} <= {2'b10, a, w, d};
    @(posedge clock_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    chk(32'(pready_o), 32'h1, "apb answer");
    if (pready_o !== 1'b1) end_sim();
    rd = prdata_o;
    er = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask : apb
  // one device byte access through the command registers
  task automatic dev(input logic w, input logic [14:0] a, input logic [7:0] d);
    int n;
    apb(`RBS_OFS_ADDR, 1'b1, 32'(a));
    apb(`RBS_OFS_WDATA, 1'b1, 32'(d));
    apb(`RBS_OFS_CTRL, 1'b1, {30'h0000_0000, w, 1'b1});
    n = 0;
    do begin
      apb(`RBS_OFS_STATUS, 1'b0, 32'h0000_0000);
      n++;
    end while (rd[1] !== 1'b1 && n < 32);
    st = rd;
    chk(32'(st[1]), 32'h1, "access done");
    if (st[1] !== 1'b1) end_sim();
    if (!w) apb(`RBS_OFS_RDATA, 1'b0, 32'h0000_0000);
  endtask : dev
  task automatic t_reset;
    chk(32'({chip_on_n_o, store_strobe_n_o, output_drive_n_o, data_lines_oe_o}), 32'h000e,
      "idle pins");
    apb(`RBS_OFS_STATUS, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "status after reset");
    apb(12'h020, 1'b0, 32'h0000_0000);
    chk(32'(er), 32'h1, "unmapped offset refused");
    $display("test reset ended");
  endtask : t_reset
  task automatic t_mem;
    logic [14:0] a [4] = '{15'h0000, 15'h0001, 15'h4000, 15'h7ff7};
    logic [7:0]  d [4] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3};
    for (int i = 0; i < 4; i++) begin
      dev(1'b1, a[i], d[i]);
      chk(32'(mem_u.mem[a[i]]), 32'(d[i]), "byte committed");
    end
    for (int i = 0; i < 4; i++) begin
      dev(1'b0, a[i], 8'h00);
      chk(rd, 32'(d[i]), "byte read back");
    end
    $display("test memory ended");
  endtask : t_mem
  task automatic t_clock;
    dev(1'b1, `RBS_CLOCK_CTRL, 8'h80);
    chk(32'(st[2]), 32'h1, "clock byte flag");
    dev(1'b1, `RBS_SECONDS, 8'h45);
    dev(1'b0, `RBS_SECONDS, 8'h00);
    chk(rd, 32'h0000_0045, "seconds read back");
    dev(1'b0, `RBS_CLOCK_CTRL, 8'h00);
    chk(rd, 32'h0000_0080, "control byte read back");
    dev(1'b0, `RBS_CLK_FIRST - 15'h0001, 8'h00);
    chk(32'({st[2], rd[7:0]}), 32'h00c3, "plain byte below clock");
    $display("test clock bytes ended");
  endtask : t_clock
  // main sequence
  initial begin
    repeat (3) @(posedge clock_i);
    srst_i <= 1'b0;
    t_reset();
    t_mem();
    t_clock();
    end_sim();
  end
endmodule : rtc_backed_sram_port_tb_top
